// ==== hdl/emi_pkg.sv ====
// shared constants and carriers of the external memory bus interface
package emi_pkg;
    localparam int unsigned CS_NUM = 6;
    localparam int unsigned ADDR_W = 24;
    localparam int unsigned PIN_ADDR_W = 20;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned WAIT_W = 2;
    localparam int unsigned DRAM_PIN_LSB = 7;
    localparam int unsigned DRAM_PIN_W = 11;
    localparam int unsigned DRAM_COL_LSB = 1;
    localparam int unsigned DRAM_ROW_LSB = 12;
    localparam logic [3:0] BOOT_BASE_RST = 4'h0;
    localparam logic BUS_CLOCK_OUT_EN_RST = 1'b1;
    localparam logic BOOT_WIDE_RST = 1'b0;

    typedef struct packed
    {
        logic en;
        logic dram;
        logic wide;
        logic [3:0] base;
        logic [WAIT_W-1:0] waits;
    } emi_cs_cfg_s;

    localparam emi_cs_cfg_s CS_CFG_RST = '0;

    typedef struct packed
    {
        logic write;
        logic [1:0] be;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } emi_req_s;
endpackage

// ==== hdl/emi_ctrl.sv ====
// external memory bus interface: chip select decode, strobes, dram mux, wait
//
// Overview of operation
// - width strap is caught at reset release: high means 16-bit boot device
// - after reset the strap pin is a wait request; high stalls the cycle
// - boot select is enabled from reset, decoding a region based at zero
// - boot select is never a dram row strobe
// - software can move the boot select base higher
// - chip selects one to five leave reset disabled; each plain or row strobe
// - exchange lets chip select one take the boot role, based anywhere
// - chip selects two to five never exchange; each maps anywhere
// - each of six selects has own 8/16-bit width and timing
// - write strobe low only in write cycles
// - output enable strobe low only in read cycles
// - low byte strobe low whenever data lines 7..0 used; cas in dram
// - high byte strobe low whenever data lines 15..8 used; cas in dram
// - generic cycles present a 20-bit address
// - dram cycles multiplex row and column onto address lines 17..7
// - 16-bit two-way data bus, driven by the device on writes only
// - bus clock output copies the clock and can be disabled
// - dram banks of 8 MB each, selected by a row strobe select
// - bus clock output enabled at reset, turned off to high impedance
`timescale 1ns/1ns
`default_nettype none
module emi_ctrl
    import emi_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic wait_or_width_strap_in,
    input wire logic cfg_load_in,
    input wire emi_cs_cfg_s [CS_NUM-1:0] cfg_in,
    input wire logic [3:0] boot_base_in,
    input wire logic swap_in,
    input wire logic bus_clock_out_en_in,
    input wire logic req_valid_in,
    input wire emi_req_s req_in,
    output logic req_ready_out,
    output logic done_out,
    output logic err_out,
    output logic [DATA_W-1:0] rdata_out,
    output logic [PIN_ADDR_W-1:0] addr_out,
    output logic boot_select_n_out,
    output logic [CS_NUM-1:1] cs_row_strobe_n_out,
    output logic we_n_out,
    output logic oe_n_out,
    output logic low_byte_strobe_n_out,
    output logic high_byte_strobe_n_out,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe_out,
    input wire logic [DATA_W-1:0] data_in,
    output logic bus_clock_out,
    output logic bus_clock_oe_out
);
    typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_ACT} emi_state_e;

    emi_state_e state_q;
    emi_cs_cfg_s [CS_NUM-1:0] cfg_q;
    logic cfg_loaded_q;
    logic [3:0] boot_base_q;
    logic swap_q;
    logic bus_clock_out_en_q;
    logic strap_taken_q;
    logic boot_wide_q;
    emi_req_s req_q;
    logic [2:0] pin_q;
    logic wide_q;
    logic dram_q;
    logic split_q;
    logic second_q;
    logic [WAIT_W-1:0] waits_q;
    logic [WAIT_W-1:0] cnt_q;
    logic [CS_NUM-1:0] cs_n_q;
    logic hit_ok;
    logic [2:0] hit_pin;
    logic hit_wide;
    logic hit_dram;
    logic [WAIT_W-1:0] hit_waits;
    logic beat_end;

    function automatic logic cs_hit(input emi_cs_cfg_s c, input logic [ADDR_W-1:0] a);
        // a dram bank spans 8 MB, a plain window 1 MB
        cs_hit = c.en && (c.dram ? (a[23] == c.base[3]) : (a[23:20] == c.base));
    endfunction

    function automatic logic hi_byte(input emi_req_s r, input logic second);
        hi_byte = second || (r.be == 2'b10);
    endfunction

    function automatic logic [PIN_ADDR_W-1:0] pin_addr(input emi_req_s r, input logic second,
        input logic wide, input logic dram, input logic row);
        logic [PIN_ADDR_W-1:0] a;
        a = r.addr[PIN_ADDR_W-1:0];
        a[0] = wide ? 1'b0 : hi_byte(r, second);
        if (dram)
        begin
            a = '0;
            a[DRAM_PIN_LSB +: DRAM_PIN_W] = row ? r.addr[DRAM_ROW_LSB +: DRAM_PIN_W]
                : r.addr[DRAM_COL_LSB +: DRAM_PIN_W];
        end
        pin_addr = a;
    endfunction

    function automatic logic [DATA_W-1:0] lane_data(input emi_req_s r, input logic second,
        input logic wide);
        if (wide)
        begin
            lane_data = r.wdata;
        end
        else
        begin
            lane_data = {8'h00, hi_byte(r, second) ? r.wdata[15:8] : r.wdata[7:0]};
        end
    endfunction

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cfg_q <= {CS_NUM{CS_CFG_RST}};
            cfg_loaded_q <= 1'b0;
            boot_base_q <= BOOT_BASE_RST;
            swap_q <= 1'b0;
            bus_clock_out_en_q <= BUS_CLOCK_OUT_EN_RST;
        end
        else if (ce_in && cfg_load_in && state_q == ST_IDLE)
        begin
            // only taken between cycles so a live access never changes shape
            cfg_q <= cfg_in;
            cfg_loaded_q <= 1'b1;
            boot_base_q <= boot_base_in;
            swap_q <= swap_in;
            bus_clock_out_en_q <= bus_clock_out_en_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            strap_taken_q <= 1'b0;
            boot_wide_q <= BOOT_WIDE_RST;
        end
        else if (ce_in && !strap_taken_q)
        begin
            boot_wide_q <= wait_or_width_strap_in;
            strap_taken_q <= 1'b1;
        end
    end

    always_comb
    begin
        hit_ok = 1'b0;
        hit_pin = 3'd0;
        hit_wide = 1'b0;
        hit_dram = 1'b0;
        hit_waits = '0;
        // descending loop: the lowest matching select wins
        for (int k = CS_NUM - 1; k >= 1; k--)
        begin
            if (cs_hit(cfg_q[k], req_in.addr))
            begin
                hit_ok = 1'b1;
                hit_pin = (k == 1 && swap_q) ? 3'd0 : 3'(k);
                hit_wide = cfg_q[k].wide;
                hit_dram = cfg_q[k].dram && !(k == 1 && swap_q);
                hit_waits = cfg_q[k].waits;
            end
        end
        if (req_in.addr[23:20] == boot_base_q)
        begin
            hit_ok = 1'b1;
            hit_pin = swap_q ? 3'd1 : 3'd0;
            hit_wide = cfg_loaded_q ? cfg_q[0].wide : boot_wide_q;
            hit_dram = 1'b0;
            hit_waits = cfg_q[0].waits;
        end
    end

    assign req_ready_out = (state_q == ST_IDLE) && strap_taken_q;
    assign beat_end = ce_in && state_q == ST_ACT && cnt_q == '0 && !wait_or_width_strap_in;
    assign boot_select_n_out = cs_n_q[0];
    assign cs_row_strobe_n_out = cs_n_q[CS_NUM-1:1];
    // the pin is a buffered clock; gating it in logic would skew it from the bus
    assign bus_clock_out = clk_in;
    assign bus_clock_oe_out = bus_clock_out_en_q;

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_q <= ST_IDLE;
            req_q <= '0;
            pin_q <= 3'd0;
            wide_q <= 1'b0;
            dram_q <= 1'b0;
            split_q <= 1'b0;
            second_q <= 1'b0;
            waits_q <= '0;
            cnt_q <= '0;
            cs_n_q <= '1;
            addr_out <= '0;
            we_n_out <= 1'b1;
            oe_n_out <= 1'b1;
            low_byte_strobe_n_out <= 1'b1;
            high_byte_strobe_n_out <= 1'b1;
            data_out <= '0;
            data_oe_out <= 1'b0;
            rdata_out <= '0;
            done_out <= 1'b0;
            err_out <= 1'b0;
        end
        else if (ce_in)
        begin
            done_out <= 1'b0;
            err_out <= 1'b0;
            unique case (state_q)
                ST_IDLE:
                begin
                    if (req_valid_in && req_ready_out)
                    begin
                        if (!hit_ok)
                        begin
                            done_out <= 1'b1;
                            err_out <= 1'b1;
                        end
                        else
                        begin
                            req_q <= req_in;
                            pin_q <= hit_pin;
                            wide_q <= hit_wide;
                            dram_q <= hit_dram;
                            split_q <= !hit_wide && req_in.be == 2'b11;
                            second_q <= 1'b0;
                            waits_q <= hit_waits;
                            cnt_q <= hit_waits;
                            cs_n_q[hit_pin] <= 1'b0;
                            addr_out <= pin_addr(req_in, 1'b0, hit_wide, hit_dram, 1'b1);
                            data_out <= lane_data(req_in, 1'b0, hit_wide);
                            data_oe_out <= req_in.write;
                            state_q <= ST_ADDR;
                        end
                    end
                end
                ST_ADDR:
                begin
                    // dram: row was held for one cycle, now the column goes out with cas
                    if (dram_q)
                    begin
                        addr_out <= pin_addr(req_q, second_q, wide_q, 1'b1, 1'b0);
                    end
                    we_n_out <= !req_q.write;
                    oe_n_out <= req_q.write;
                    low_byte_strobe_n_out <= wide_q ? !req_q.be[0] : 1'b0;
                    high_byte_strobe_n_out <= wide_q ? !req_q.be[1] : 1'b1;
                    state_q <= ST_ACT;
                end
                ST_ACT:
                begin
                    if (cnt_q != '0)
                    begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                    else if (beat_end)
                    begin
                        if (!req_q.write && wide_q)
                        begin
                            rdata_out <= data_in;
                        end
                        else if (!req_q.write && hi_byte(req_q, second_q))
                        begin
                            rdata_out[15:8] <= data_in[7:0];
                        end
                        else if (!req_q.write)
                        begin
                            rdata_out[7:0] <= data_in[7:0];
                        end
                        we_n_out <= 1'b1;
                        oe_n_out <= 1'b1;
                        low_byte_strobe_n_out <= 1'b1;
                        high_byte_strobe_n_out <= 1'b1;
                        if (split_q && !second_q)
                        begin
                            second_q <= 1'b1;
                            cnt_q <= waits_q;
                            addr_out <= pin_addr(req_q, 1'b1, wide_q, dram_q, dram_q);
                            data_out <= lane_data(req_q, 1'b1, wide_q);
                            state_q <= ST_ADDR;
                        end
                        else
                        begin
                            cs_n_q <= '1;
                            data_oe_out <= 1'b0;
                            done_out <= 1'b1;
                            state_q <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    default clocking dflt_cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    a_ready_after_strap: assert property (ce_in && !strap_taken_q |=> strap_taken_q
        && boot_wide_q == $past(wait_or_width_strap_in) && $past(!req_ready_out))
        else $error("width strap not caught before requests");
    a_wait_holds_bus: assert property (state_q == ST_ACT && cnt_q == '0
        && wait_or_width_strap_in |=> state_q == ST_ACT && $stable(addr_out)
        && $stable(cs_n_q) && $stable(low_byte_strobe_n_out))
        else $error("bus moved while wait was high");
    a_boot_not_ras: assert property (state_q != ST_IDLE && pin_q == 3'd0 |-> !dram_q)
        else $error("boot select used as row strobe");
    a_we_write_only: assert property (!we_n_out |-> req_q.write && state_q == ST_ACT)
        else $error("write strobe outside a write");
    a_oe_read_only: assert property (!oe_n_out |-> !req_q.write && oe_n_out == !we_n_out)
        else $error("output enable outside a read");
    a_low_lane_used: assert property (ce_in && state_q == ST_ADDR && (!wide_q || req_q.be[0])
        |=> !low_byte_strobe_n_out)
        else $error("low byte strobe missing");
    a_high_lane_used: assert property (ce_in && state_q == ST_ADDR && wide_q && req_q.be[1]
        |=> !high_byte_strobe_n_out)
        else $error("high byte strobe missing");
    a_narrow_high_off: assert property (!wide_q && state_q != ST_IDLE
        |-> high_byte_strobe_n_out)
        else $error("high lane used on an 8-bit select");
    a_split_second: assert property (beat_end && split_q && !second_q
        |=> state_q == ST_ADDR && second_q && addr_out[0] == !dram_q)
        else $error("split access missed its second byte");
    a_dram_row_col: assert property (ce_in && state_q == ST_ADDR && dram_q
        |=> addr_out == pin_addr(req_q, second_q, wide_q, 1'b1, 1'b0))
        else $error("dram column not presented");
    a_data_write_only: assert property (data_oe_out |-> req_q.write && state_q != ST_IDLE)
        else $error("data bus driven outside a write");
    a_clock_out_en: assert property (ce_in && cfg_load_in && state_q == ST_IDLE
        |=> bus_clock_oe_out == $past(bus_clock_out_en_in))
        else $error("bus clock enable not loaded");

    c_write_done: cover property (done_out && !err_out && req_q.write);
    c_split_read: cover property (beat_end && split_q && second_q && !req_q.write);
    c_dram_access: cover property (beat_end && dram_q);
    c_wait_stall: cover property (state_q == ST_ACT && cnt_q == '0 && wait_or_width_strap_in);
endmodule
`default_nettype wire

// ==== test/emi_mem_model.sv ====
// byte-wide memory and wait-state source on the far side of the external bus
`timescale 1ns/1ns
`default_nettype none
module emi_mem_model
    import emi_pkg::*;
(
    input wire logic clk_in,
    input wire logic strap_phase_in,
    input wire logic strap_in,
    input wire logic [2:0] stall_in,
    input wire logic [PIN_ADDR_W-1:0] addr_in,
    input wire logic sel_n_in,
    input wire logic we_n_in,
    input wire logic oe_n_in,
    input wire logic lbs_n_in,
    input wire logic hbs_n_in,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic wait_out
);
    logic [7:0] mem [256];
    logic [2:0] stall_q = 3'h0;
    logic [DATA_W-1:0] last_q = 16'h5a5a;
    wire logic cyc = !sel_n_in && !(we_n_in && oe_n_in);
    always_comb
    begin
        wait_out = strap_phase_in ? strap_in : (cyc && stall_q < stall_in);
        if (cyc && !oe_n_in)
            data_out = {mem[addr_in[7:0] | 8'h01], mem[addr_in[7:0]]};
        else
            data_out = ~last_q; // released bus must not keep showing old data
    end
    always_ff @(posedge clk_in)
    begin
        stall_q <= cyc ? stall_q + {2'h0, stall_q < stall_in} : 3'h0;
        if (cyc && !oe_n_in)
            last_q <= data_out;
        if (cyc && !we_n_in && !lbs_n_in)
            mem[addr_in[7:0]] <= data_in[7:0];
        if (cyc && !we_n_in && !hbs_n_in)
            mem[addr_in[7:0] | 8'h01] <= data_in[15:8];
    end
endmodule
`default_nettype wire

// ==== test/external_memory_bus_interface_tb_top.sv ====
// self-checking bench of the external memory bus interface
`timescale 1ns/1ns
`default_nettype none
module external_memory_bus_interface_tb_top
    import emi_pkg::*;
;
    typedef struct packed
    {
        logic wr;
        logic [1:0] be;
        logic [23:0] a;
        logic [15:0] wd;
        logic [15:0] rd;
        logic [9:0] seen;
        logic er;
    } emi_tb_row_s;
    localparam emi_tb_row_s ROWS [6] = '{
        '{1'b1, 2'h3, 24'h000010, 16'h1234, 16'h0, 10'h2c1, 1'b0},
        '{1'b1, 2'h1, 24'h000012, 16'h00ab, 16'h0, 10'h281, 1'b0},
        '{1'b1, 2'h2, 24'h000012, 16'hcd00, 16'h0, 10'h241, 1'b0},
        '{1'b0, 2'h3, 24'h000012, 16'h0, 16'hcdab, 10'h1c1, 1'b0},
        '{1'b0, 2'h3, 24'h000010, 16'h0, 16'h1234, 10'h1c1, 1'b0},
        '{1'b0, 2'h3, 24'h500000, 16'h0, 16'h0, 10'h000, 1'b1}};
    logic clk_in, rst_in, ce_in, cfg_load_in, swap_in, bus_clock_out_en_in, req_valid_in;
    logic strap_phase, strap, req_ready_out, done_out, err_out, boot_select_n_out;
    logic we_n_out, oe_n_out, low_byte_strobe_n_out, high_byte_strobe_n_out;
    logic data_oe_out, bus_clock_oe_out, hold_q;
    logic [2:0] stall;
    logic [3:0] boot_base_in;
    logic [5:1] cs_row_strobe_n_out;
    emi_cs_cfg_s [CS_NUM-1:0] cfg;
    emi_req_s req_in;
    logic [DATA_W-1:0] rdata_out, data_out, mem_data, rd;
    logic [PIN_ADDR_W-1:0] addr_out, a_cap;
    logic [9:0] seen;
    logic [10:0] row_cap, col_cap;
    logic [29:0] snap;
    logic er;
    wire logic wait_line;
    int n_errors = 0;
    int samples_checked = 0;
    int lat, l0, cycles = 0;
    wire logic [DATA_W-1:0] bus_data = data_oe_out ? data_out : mem_data;
    wire logic [5:0] sel = ~{cs_row_strobe_n_out, boot_select_n_out};
    wire logic strb = !low_byte_strobe_n_out || !high_byte_strobe_n_out;
    wire logic [29:0] pins = {addr_out, sel, we_n_out, oe_n_out,
        low_byte_strobe_n_out, high_byte_strobe_n_out};

    emi_ctrl uut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .wait_or_width_strap_in(wait_line), .cfg_load_in(cfg_load_in), .cfg_in(cfg),
        .boot_base_in(boot_base_in), .swap_in(swap_in), .bus_clock_out_en_in(bus_clock_out_en_in),
        .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
        .done_out(done_out), .err_out(err_out), .rdata_out(rdata_out), .addr_out(addr_out),
        .boot_select_n_out(boot_select_n_out), .cs_row_strobe_n_out(cs_row_strobe_n_out),
        .we_n_out(we_n_out), .oe_n_out(oe_n_out),
        .low_byte_strobe_n_out(low_byte_strobe_n_out),
        .high_byte_strobe_n_out(high_byte_strobe_n_out), .data_out(data_out),
        .data_oe_out(data_oe_out), .data_in(bus_data), .bus_clock_out(),
        .bus_clock_oe_out(bus_clock_oe_out));

    emi_mem_model mem (.clk_in(clk_in), .strap_phase_in(strap_phase), .strap_in(strap),
        .stall_in(stall), .addr_in(addr_out), .sel_n_in(~|sel), .we_n_in(we_n_out),
        .oe_n_in(oe_n_out), .lbs_n_in(low_byte_strobe_n_out),
        .hbs_n_in(high_byte_strobe_n_out), .data_in(bus_data), .data_out(mem_data),
        .wait_out(wait_line));

    always #20 clk_in = ~clk_in;

    task automatic summarize();
        if (n_errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // bus monitor: strobe history per access, captured addresses, stall hold
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            n_errors++;
            summarize();
        end
        if (req_valid_in && req_ready_out)
            seen <= '0;
        else
            seen <= seen | {!we_n_out, !oe_n_out, !low_byte_strobe_n_out,
                !high_byte_strobe_n_out, sel};
        if (|sel && !strb)
            row_cap <= addr_out[17:7];
        if (strb)
        begin
            col_cap <= addr_out[17:7];
            a_cap <= addr_out;
        end
        if (hold_q)
            check(pins, snap);
        if ((!oe_n_out && data_oe_out) || (!we_n_out && !data_oe_out))
            check(32'h1, 32'h0);
        hold_q <= wait_line && strb && !rst_in && !strap_phase;
        snap <= pins;
    end

    task automatic access(input logic wr, input logic [1:0] be, input logic [23:0] a,
        input logic [15:0] wd);
        req_valid_in <= 1'b1;
        req_in <= '{wr, be, a, wd};
        do @(posedge clk_in); while (req_ready_out !== 1'b1);
        req_valid_in <= 1'b0;
        lat = 0;
        do
        begin
            @(posedge clk_in);
            lat++;
        end
        while (done_out !== 1'b1 && lat < 40);
        er = err_out;
        rd = rdata_out;
    endtask

    task automatic run(input emi_tb_row_s r);
        access(r.wr, r.be, r.a, r.wd);
        check(er, r.er);
        check(seen, r.seen);
        if (!r.wr && !r.er)
            check(rd, r.rd);
    endtask

    task automatic do_reset(input logic s);
        rst_in <= 1'b1;
        strap_phase <= 1'b1;
        strap <= s;
        repeat (3) @(posedge clk_in);
        check({~sel, we_n_out, oe_n_out, low_byte_strobe_n_out, high_byte_strobe_n_out,
            bus_clock_oe_out, req_ready_out}, 32'hffe);
        rst_in <= 1'b0;
        @(posedge clk_in);
        strap_phase <= 1'b0;
    endtask

    task automatic load(input logic sw, input logic [3:0] bb, input logic ce);
        swap_in <= sw;
        boot_base_in <= bb;
        bus_clock_out_en_in <= ce;
        cfg_load_in <= 1'b1;
        @(posedge clk_in);
        cfg_load_in <= 1'b0;
        @(posedge clk_in);
    endtask

    initial
    begin
        clk_in = 1'b0;
        rst_in = 1'b1;
        ce_in = 1'b1;
        strap_phase = 1'b1;
        strap = 1'b1;
        stall = 3'h0;
        cfg_load_in = 1'b0;
        cfg = '0;
        boot_base_in = 4'h0;
        swap_in = 1'b0;
        bus_clock_out_en_in = 1'b1;
        req_valid_in = 1'b0;
        req_in = '0;
        hold_q = 1'b0;
        do_reset(1'b1);
        foreach (ROWS[i])
            run(ROWS[i]);
        access(1'b0, 2'h3, 24'h000010, 16'h0);
        l0 = lat;
        stall <= 3'h3;
        access(1'b0, 2'h3, 24'h000010, 16'h0);
        check(lat, l0 + 3);
        stall <= 3'h0;
        // boot select told to be dram on purpose: it must stay a plain select
        cfg[0] <= '{1'b1, 1'b1, 1'b1, 4'h0, 2'h0};
        cfg[2] <= '{1'b1, 1'b0, 1'b0, 4'h3, 2'h0};
        cfg[3] <= '{1'b1, 1'b1, 1'b1, 4'h8, 2'h0};
        cfg[4] <= '{1'b1, 1'b0, 1'b1, 4'h4, 2'h2};
        load(1'b0, 4'h1, 1'b0);
        run('{1'b0, 2'h3, 24'h000010, 16'h0, 16'h0, 10'h000, 1'b1});
        run('{1'b0, 2'h3, 24'h100010, 16'h0, 16'h1234, 10'h1c1, 1'b0});
        check(a_cap, 20'h00010);
        check(bus_clock_oe_out, 1'b0);
        run('{1'b0, 2'h3, 24'h400010, 16'h0, 16'h1234, 10'h1d0, 1'b0});
        check(lat, l0 + 2);
        run('{1'b1, 2'h3, 24'h300020, 16'hbeef, 16'h0, 10'h284, 1'b0});
        run('{1'b0, 2'h3, 24'h300020, 16'h0, 16'hbeef, 10'h184, 1'b0});
        access(1'b0, 2'h3, 24'h812344, 16'h0);
        check(seen, 10'h1c8);
        check(row_cap, 11'h012);
        check(col_cap, 11'h1a2);
        cfg[1] <= '{1'b1, 1'b0, 1'b1, 4'h6, 2'h0};
        load(1'b1, 4'h1, 1'b1);
        run('{1'b0, 2'h3, 24'h100010, 16'h0, 16'h1234, 10'h1c2, 1'b0});
        run('{1'b0, 2'h3, 24'h600010, 16'h0, 16'h1234, 10'h1c1, 1'b0});
        run('{1'b0, 2'h3, 24'h300020, 16'h0, 16'hbeef, 10'h184, 1'b0});
        check(bus_clock_oe_out, 1'b1);
        do_reset(1'b0);
        run('{1'b0, 2'h3, 24'h000010, 16'h0, 16'h1234, 10'h181, 1'b0});
        summarize();
    end
endmodule
`default_nettype wire
